// *** phybc_defines.svh ***
// phybc_defines.svh: constants for the basic control low-bit register block.
// assumes inclusion by bare name from every design file that needs it.
`ifndef PHYBC_DEFINES_SVH
`define PHYBC_DEFINES_SVH

// management register number of the control register
`define PHYBC_REG_CONTROL 5'h00

// field positions inside the control register
`define PHYBC_BIT_AN_ENABLE 12
`define PHYBC_BIT_POWER_DOWN 11
`define PHYBC_BIT_ISOLATE 10
`define PHYBC_BIT_RESTART 9
`define PHYBC_BIT_DUPLEX 8
`define PHYBC_BIT_COLTEST 7
`define PHYBC_RSVD_ZERO 7'h00
`define PHYBC_UPPER_MSB 15
`define PHYBC_UPPER_LSB 12

// reset values of the stored control bits
`define PHYBC_RST_POWER_DOWN 1'b0
`define PHYBC_RST_ISOLATE 1'b0
`define PHYBC_RST_RESTART 1'b0
`define PHYBC_RST_COLTEST 1'b0
`define PHYBC_RST_DUPLEX 1'b0

// management frame layout
`define PHYBC_PREAMBLE_ONES 6'd32
`define PHYBC_OP_READ 2'b10
`define PHYBC_OP_WRITE 2'b01
`define PHYBC_OP_LAST 5'd1
`define PHYBC_ADDR_LAST 5'd4
`define PHYBC_TA_LAST 5'd1
`define PHYBC_DATA_LAST 5'd15
`define PHYBC_CNT_ZERO 5'd0
`define PHYBC_CNT_ONE 5'd1

// strap is taken once the two-stage synchroniser has filled
`define PHYBC_STRAP_SETTLE 2'd2

// number of pin inputs passing the synchroniser
`define PHYBC_SYNC_WIDTH 5

`endif

// *** phybc_pkg.sv ***
// phybc_pkg.sv: types for the basic control low-bit register block.
// assumes phybc_defines.svh is on the include path.
`include "phybc_defines.svh"

package phybc_pkg;

   typedef enum logic [2:0] {
      PHYBC_ST_PREAMBLE,
      PHYBC_ST_START,
      PHYBC_ST_OPCODE,
      PHYBC_ST_PHYADDR,
      PHYBC_ST_REGADDR,
      PHYBC_ST_TURN,
      PHYBC_ST_DATA
   } phybc_frame_state_type;

   typedef struct packed {
      // frame engine
      logic mdc_prev;
      phybc_frame_state_type state;
      logic [4:0] bit_cnt;
      logic [5:0] ones_cnt;
      logic [1:0] opcode;
      logic [4:0] phy_addr;
      logic [4:0] reg_addr;
      logic [15:0] shift;
      logic mdio_out;
      logic mdio_oe;
      // strap capture
      logic [1:0] strap_cnt;
      logic strap_done;
      // control bits
      logic power_down;
      logic isolate;
      logic restart;
      logic duplex;
      logic coltest;
      // registered outputs
      logic col;
      logic power_down_active;
      logic mii_isolate;
      logic an_restart_req;
      logic full_duplex;
      logic speed_100;
      logic wr_stb;
      logic [15:0] wr_data;
   } phybc_state_type;

endpackage : phybc_pkg

// *** phybc_sync.sv ***
// phybc_sync.sv: two-stage synchroniser for pin inputs.
// assumes the inputs are asynchronous levels; clock enable freezes it too.
`timescale 1ns/1ps
`default_nettype none

module phybc_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1_reg;
   logic [WIDTH-1:0] stage2_reg;

   // first stage feeds only the second
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         stage1_reg <= '0;
         stage2_reg <= '0;
      end
      else if (ce)
      begin
         stage1_reg <= async_in;
         stage2_reg <= stage1_reg;
      end
   end

   assign sync_out = stage2_reg;
endmodule : phybc_sync

`default_nettype wire

// *** phybc_top.sv ***
// phybc_top.sv: low twelve bits of the basic mode control register, with the
// serial management frame engine that reaches it.
// assumes mdc, mdio, tx_en, the power-down pin and the strap are asynchronous;
// negotiation and upper control bits live in neighbouring logic on clk.
//
// Summary of operation
// - power-down bit shuts transceiver functions, only management registers stay alive
// - effective power-down is control bit ORed with external pin
// - external active-low pin asserted sets the power-down bit
// - isolate bit set detaches port from MII, management still works
// - writing one to restart bit restarts auto-negotiation from the beginning
// - restart write ignored while auto-negotiation enable is zero
// - restart bit reads one until negotiation begins, then self-clears
// - writing zero to restart bit never disturbs running negotiation
// - without negotiation, duplex bit selects full or half; reset from strap
// - collision test: COL follows TX_EN assertion within 512 bit times
// - collision test: COL drops within 4 bit times after TX_EN drops
// - reserved bits 6:0 ignore writes and read as zero
// - with negotiation enabled, duplex and speed bits are ignored
`timescale 1ns/1ps
`default_nettype none
`include "phybc_defines.svh"

module phybc_top (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic mdc,
   input wire logic mdio_in,
   output logic mdio_out,
   output logic mdio_oe,
   input wire logic [4:0] phy_address,
   input wire logic power_down_irq_pin_n,
   input wire logic duplex_strap,
   input wire logic tx_en,
   input wire logic [3:0] upper_ctrl_bits,
   input wire logic an_enable,
   input wire logic speed_sel,
   input wire logic an_started,
   input wire logic an_full_duplex,
   input wire logic an_speed_100,
   output logic col,
   output logic power_down_active,
   output logic mii_isolate,
   output logic an_restart_req,
   output logic full_duplex,
   output logic speed_100,
   output logic wr_stb,
   output logic [15:0] wr_data
);
   import phybc_pkg::*;

   phybc_state_type r_reg;
   phybc_state_type r_next;
   phybc_state_type r_reset;

   logic [`PHYBC_SYNC_WIDTH-1:0] pins_async;
   logic [`PHYBC_SYNC_WIDTH-1:0] pins_sync;
   logic mdc_s;
   logic mdio_s;
   logic pd_pin_s;
   logic tx_en_s;
   logic strap_s;
   logic mdc_rise;
   logic mdc_fall;
   logic frame_read;
   logic frame_ours;
   logic [15:0] read_word;

   // pin inverted ahead of the synchroniser, so its zero reset reads as released
   assign pins_async = {mdc, mdio_in, ~power_down_irq_pin_n, tx_en, duplex_strap};

   phybc_sync #(
      .WIDTH(`PHYBC_SYNC_WIDTH)
   ) u_sync (
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .async_in(pins_async),
      .sync_out(pins_sync)
   );

   assign mdc_s = pins_sync[4];
   assign mdio_s = pins_sync[3];
   assign pd_pin_s = pins_sync[2];
   assign tx_en_s = pins_sync[1];
   assign strap_s = pins_sync[0];

   assign mdc_rise = mdc_s & ~r_reg.mdc_prev;
   assign mdc_fall = ~mdc_s & r_reg.mdc_prev;
   assign frame_ours = (r_reg.phy_addr == phy_address);
   assign frame_read = (r_reg.opcode == `PHYBC_OP_READ);

   // read view of register zero; upper bits come from neighbouring logic
   always_comb
   begin
      read_word = '0;
      read_word[`PHYBC_UPPER_MSB:`PHYBC_UPPER_LSB] = upper_ctrl_bits;
      read_word[`PHYBC_BIT_POWER_DOWN] = r_reg.power_down;
      read_word[`PHYBC_BIT_ISOLATE] = r_reg.isolate;
      read_word[`PHYBC_BIT_RESTART] = r_reg.restart;
      read_word[`PHYBC_BIT_DUPLEX] = r_reg.duplex;
      read_word[`PHYBC_BIT_COLTEST] = r_reg.coltest;
      read_word[`PHYBC_BIT_COLTEST-1:0] = `PHYBC_RSVD_ZERO;
   end

   always_comb
   begin
      r_reset = '0;
      r_reset.state = PHYBC_ST_PREAMBLE;
      r_reset.power_down = `PHYBC_RST_POWER_DOWN;
      r_reset.isolate = `PHYBC_RST_ISOLATE;
      r_reset.restart = `PHYBC_RST_RESTART;
      r_reset.duplex = `PHYBC_RST_DUPLEX;
      r_reset.coltest = `PHYBC_RST_COLTEST;
   end

   always_comb
   begin
      r_next = r_reg;
      r_next.mdc_prev = mdc_s;
      r_next.wr_stb = 1'b0;

      // frame engine samples mdio on rising mdc
      if (mdc_rise)
      begin
         r_next.bit_cnt = r_reg.bit_cnt + `PHYBC_CNT_ONE;
         case (r_reg.state)
            PHYBC_ST_PREAMBLE:
            begin
               if (mdio_s)
               begin
                  if (r_reg.ones_cnt != `PHYBC_PREAMBLE_ONES)
                  begin
                     r_next.ones_cnt = r_reg.ones_cnt + 6'h01;
                  end
               end
               else
               begin
                  // a zero after a full preamble is the first start bit
                  if (r_reg.ones_cnt == `PHYBC_PREAMBLE_ONES)
                  begin
                     r_next.state = PHYBC_ST_START;
                  end
                  r_next.ones_cnt = '0;
               end
            end
            PHYBC_ST_START:
            begin
               r_next.bit_cnt = `PHYBC_CNT_ZERO;
               r_next.state = mdio_s ? PHYBC_ST_OPCODE : PHYBC_ST_PREAMBLE;
            end
            PHYBC_ST_OPCODE:
            begin
               r_next.opcode = {r_reg.opcode[0], mdio_s};
               if (r_reg.bit_cnt == `PHYBC_OP_LAST)
               begin
                  r_next.bit_cnt = `PHYBC_CNT_ZERO;
                  r_next.state = PHYBC_ST_PHYADDR;
               end
            end
            PHYBC_ST_PHYADDR:
            begin
               r_next.phy_addr = {r_reg.phy_addr[3:0], mdio_s};
               if (r_reg.bit_cnt == `PHYBC_ADDR_LAST)
               begin
                  r_next.bit_cnt = `PHYBC_CNT_ZERO;
                  r_next.state = PHYBC_ST_REGADDR;
               end
            end
            PHYBC_ST_REGADDR:
            begin
               r_next.reg_addr = {r_reg.reg_addr[3:0], mdio_s};
               if (r_reg.bit_cnt == `PHYBC_ADDR_LAST)
               begin
                  r_next.bit_cnt = `PHYBC_CNT_ZERO;
                  r_next.state = PHYBC_ST_TURN;
                  // unsupported opcodes drop the frame and need a fresh preamble
                  if (r_reg.opcode != `PHYBC_OP_READ && r_reg.opcode != `PHYBC_OP_WRITE)
                  begin
                     r_next.state = PHYBC_ST_PREAMBLE;
                  end
               end
            end
            PHYBC_ST_TURN:
            begin
               if (r_reg.bit_cnt == `PHYBC_TA_LAST)
               begin
                  r_next.bit_cnt = `PHYBC_CNT_ZERO;
                  r_next.state = PHYBC_ST_DATA;
                  // other registers read as zero here; they live elsewhere
                  r_next.shift = (r_reg.reg_addr == `PHYBC_REG_CONTROL) ? read_word : '0;
               end
            end
            PHYBC_ST_DATA:
            begin
               if (!frame_read)
               begin
                  r_next.shift = {r_reg.shift[14:0], mdio_s};
               end
               if (r_reg.bit_cnt == `PHYBC_DATA_LAST)
               begin
                  r_next.state = PHYBC_ST_PREAMBLE;
                  r_next.ones_cnt = '0;
                  if (!frame_read && frame_ours)
                  begin
                     r_next.wr_stb = 1'b1;
                     r_next.wr_data = {r_reg.shift[14:0], mdio_s};
                  end
               end
            end
            default:
            begin
               r_next.state = PHYBC_ST_PREAMBLE;
            end
         endcase
      end

      // read data leaves on falling mdc so the controller samples it stable
      if (mdc_fall)
      begin
         r_next.mdio_oe = 1'b0;
         r_next.mdio_out = 1'b0;
         if (frame_read && frame_ours)
         begin
            if (r_reg.state == PHYBC_ST_TURN && r_reg.bit_cnt == `PHYBC_TA_LAST)
            begin
               r_next.mdio_oe = 1'b1;
            end
            else if (r_reg.state == PHYBC_ST_DATA)
            begin
               r_next.mdio_oe = 1'b1;
               r_next.mdio_out = r_reg.shift[15];
               r_next.shift = {r_reg.shift[14:0], 1'b0};
            end
         end
      end

      // strap caught once the synchroniser holds a settled level
      if (!r_reg.strap_done)
      begin
         if (r_reg.strap_cnt == `PHYBC_STRAP_SETTLE)
         begin
            r_next.duplex = strap_s;
            r_next.strap_done = 1'b1;
         end
         else
         begin
            r_next.strap_cnt = r_reg.strap_cnt + 2'h1;
         end
      end

      if (an_started)
      begin
         r_next.restart = 1'b0;
      end

      if (r_reg.wr_stb && r_reg.reg_addr == `PHYBC_REG_CONTROL)
      begin
         r_next.power_down = r_reg.wr_data[`PHYBC_BIT_POWER_DOWN];
         r_next.isolate = r_reg.wr_data[`PHYBC_BIT_ISOLATE];
         r_next.duplex = r_reg.wr_data[`PHYBC_BIT_DUPLEX];
         r_next.coltest = r_reg.wr_data[`PHYBC_BIT_COLTEST];
         // restart only on one with negotiation on
         if (r_reg.wr_data[`PHYBC_BIT_RESTART] && an_enable)
         begin
            r_next.restart = 1'b1;
         end
      end

      if (pd_pin_s)
      begin
         r_next.power_down = 1'b1;
      end

      r_next.power_down_active = r_next.power_down | pd_pin_s;
      r_next.mii_isolate = r_next.isolate;
      r_next.an_restart_req = r_next.restart;
      r_next.col = r_reg.coltest & tx_en_s;
      r_next.full_duplex = an_enable ? an_full_duplex : r_reg.duplex;
      r_next.speed_100 = an_enable ? an_speed_100 : speed_sel;
   end

   // clock enable low freezes everything
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         r_reg <= r_reset;
      end
      else if (ce)
      begin
         r_reg <= r_next;
      end
   end

   assign mdio_out = r_reg.mdio_out;
   assign mdio_oe = r_reg.mdio_oe;
   assign col = r_reg.col;
   assign power_down_active = r_reg.power_down_active;
   assign mii_isolate = r_reg.mii_isolate;
   assign an_restart_req = r_reg.an_restart_req;
   assign full_duplex = r_reg.full_duplex;
   assign speed_100 = r_reg.speed_100;
   assign wr_stb = r_reg.wr_stb;
   assign wr_data = r_reg.wr_data;
endmodule : phybc_top

`default_nettype wire

// *** phybc_top_properties.sv ***
// phybc_top_properties.sv: concurrent checks on the control block's ports.
// assumes one clock domain and the bind in the bench top file.
`timescale 1ns/1ps
`default_nettype none

module phybc_top_properties (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic tx_en,
   input wire logic power_down_irq_pin_n,
   input wire logic an_enable,
   input wire logic speed_sel,
   input wire logic an_started,
   input wire logic an_full_duplex,
   input wire logic an_speed_100,
   input wire logic col,
   input wire logic power_down_active,
   input wire logic mii_isolate,
   input wire logic an_restart_req,
   input wire logic full_duplex,
   input wire logic speed_100,
   input wire logic mdio_out,
   input wire logic mdio_oe,
   input wire logic wr_stb,
   input wire logic [15:0] wr_data
);
   default clocking cb @(posedge clk);
   endclocking
   // frozen cycles are not judged
   default disable iff (!rstn || !ce);

   a_col_needs_tx: assert property (col |-> $past(tx_en, 3))
      else $error("col high without transmit enable");
   a_col_drops: assert property (!tx_en [*4] |-> !col)
      else $error("col stayed high after transmit enable dropped");
   a_pin_sets_down: assert property (!power_down_irq_pin_n [*5] |-> power_down_active)
      else $error("power down pin not reflected");
   a_down_cleared_by_write: assert property ($fell(power_down_active)
      |-> $past(wr_stb) && !$past(wr_data[11]))
      else $error("power down left without a write of zero");
   a_isolate_from_write: assert property ($changed(mii_isolate)
      |-> $past(wr_stb) && mii_isolate == $past(wr_data[10]))
      else $error("isolate changed without a write");
   a_restart_needs_enable: assert property ($rose(an_restart_req)
      |-> $past(wr_stb) && $past(an_enable) && $past(wr_data[9]))
      else $error("restart raised without enabled write");
   a_restart_holds: assert property (an_restart_req && !an_started && !$past(an_started)
      |=> an_restart_req)
      else $error("restart cleared before negotiation began");
   a_restart_clears: assert property (an_started && !wr_stb |=> !an_restart_req)
      else $error("restart did not self clear");
   a_duplex_select: assert property ($past(an_enable)
      |-> full_duplex == $past(an_full_duplex))
      else $error("duplex not taken from negotiation");
   // strap load lands a few cycles after reset, hence the reset look-back
   a_duplex_held: assert property (!$past(an_enable) && !$past(an_enable, 2)
      && !$past(wr_stb, 2) && $past(rstn, 5) |-> $stable(full_duplex))
      else $error("manual duplex changed without a write");
   a_speed_select: assert property (1'h1
      |=> speed_100 == $past(an_enable ? an_speed_100 : speed_sel))
      else $error("speed source wrong");
   a_ta_low: assert property ($rose(mdio_oe) |-> !mdio_out)
      else $error("turnaround not driven low");
   a_stb_pulse: assert property (wr_stb |=> !wr_stb)
      else $error("write strobe longer than one cycle");

   cover property ($rose(col));
   cover property (an_started && an_restart_req);
   cover property ($rose(mdio_oe));
   cover property ($fell(power_down_active));
endmodule : phybc_top_properties

`default_nettype wire

// *** phybc_smc_model.sv ***
// phybc_smc_model.sv: station management controller sending whole frames.
// assumes the bench resolves the mdio wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none

module phybc_smc_model (
   input wire logic clk,
   input wire logic mdio_wire,
   output logic mdc,
   output logic mdio_val,
   output logic mdio_drv
);
   initial
   begin
      mdc = 1'h0;
      mdio_val = 1'h1;
      mdio_drv = 1'h0;
   end

   // halves of 6 clk, safely above the 3 clk the engine needs
   task automatic bit_cyc(input logic v, input logic drv, output logic s);
      mdc <= 1'h0;
      mdio_val <= v;
      mdio_drv <= drv;
      repeat (6) @(posedge clk);
      s = mdio_wire;
      mdc <= 1'h1;
      repeat (6) @(posedge clk);
   endtask : bit_cyc

   task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
      input logic [15:0] wd, output logic [15:0] rd);
      logic [13:0] hdr;
      logic s;
      hdr = {2'h1, op, pa, ra};
      rd = 16'h0000;
      @(posedge clk);
      repeat (32) bit_cyc(1'h1, 1'h1, s);
      for (int i = 13; i >= 0; i--) bit_cyc(hdr[i], 1'h1, s);
      bit_cyc(1'h1, op == 2'h1, s);
      bit_cyc(1'h0, op == 2'h1, s);
      for (int i = 15; i >= 0; i--)
      begin
         bit_cyc(wd[i], op == 2'h1, s);
         rd[i] = s;
      end
      mdc <= 1'h0;
      mdio_drv <= 1'h0;
   endtask : frame
endmodule : phybc_smc_model

`default_nettype wire

// *** tb_phy_basic_control_low_bits.sv ***
// tb_phy_basic_control_low_bits.sv: self-checking bench for the control block.
// assumes the frame model and the checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none

module tb_phy_basic_control_low_bits;
   localparam logic [4:0] ADDR = 5'h0b;
   logic clk = 1'h0, rstn = 1'h0, ce = 1'h1, tx_en = 1'h0, power_down_irq_pin_n = 1'h1;
   logic duplex_strap = 1'h0, an_enable = 1'h0, speed_sel = 1'h0, an_started = 1'h0;
   logic an_full_duplex = 1'h0, an_speed_100 = 1'h0;
   logic [3:0] upper_ctrl_bits = 4'h0;
   logic mdc, m_val, m_drv, mdio_out, mdio_oe, col, power_down_active, mii_isolate;
   logic an_restart_req, full_duplex, speed_100, wr_stb;
   logic [15:0] wr_data, r, d;
   logic ae;
   int n_errors = 0, checks_done = 0, n_stb = 0, seed;
   wire logic mdio_wire = mdio_oe ? mdio_out : (m_drv ? m_val : 1'h1);

   phybc_top i_phybc_top (.clk, .rstn, .ce, .mdc, .mdio_in(mdio_wire), .mdio_out, .mdio_oe,
      .phy_address(ADDR), .power_down_irq_pin_n, .duplex_strap, .tx_en, .upper_ctrl_bits,
      .an_enable, .speed_sel, .an_started, .an_full_duplex, .an_speed_100, .col,
      .power_down_active, .mii_isolate, .an_restart_req, .full_duplex, .speed_100,
      .wr_stb, .wr_data);
   phybc_smc_model i_phybc_smc_model (.clk, .mdio_wire, .mdc, .mdio_val(m_val),
      .mdio_drv(m_drv));

   initial
   begin
      forever #5 clk = ~clk;
   end
   always @(posedge clk) if (wr_stb === 1'h1) n_stb++;

   task automatic test_done;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : test_done

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
      checks_done++;
      if (s !== e)
      begin
         $display("wrong value %s expected %h seen %h", nm, e, s);
         n_errors++;
      end
   endtask : chk

   task automatic wr(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] v);
      logic [15:0] x;
      i_phybc_smc_model.frame(2'h1, pa, ra, v, x);
      repeat (10) @(posedge clk);
   endtask : wr

   task automatic rd(input logic [4:0] ra, output logic [15:0] v);
      i_phybc_smc_model.frame(2'h2, ADDR, ra, 16'h0000, v);
      repeat (4) @(posedge clk);
   endtask : rd

   // read-back expected after a write; restart bit given apart
   function automatic logic [15:0] exp_rd(input logic [15:0] v, input logic rs);
      return {upper_ctrl_bits, v[11:10], rs, v[8:7], 7'h00};
   endfunction : exp_rd

   initial
   begin
      seed = $urandom(5093);
      duplex_strap <= $urandom;
      upper_ctrl_bits <= $urandom;
      repeat (12) @(posedge clk);
      rstn <= 1'h1;
      repeat (8) @(posedge clk);
      rd(5'h00, r);
      chk("reset word", {upper_ctrl_bits, 3'h0, duplex_strap, 8'h00}, r);
      chk("strap duplex", {15'h0, duplex_strap}, {15'h0, full_duplex});
      for (int k = 0; k < 8; k++)
      begin
         d = $urandom;
         d[9] = 1'h0;
         ae = $urandom;
         an_enable <= ae;
         an_full_duplex <= $urandom;
         an_speed_100 <= $urandom;
         speed_sel <= $urandom;
         upper_ctrl_bits <= $urandom;
         wr(ADDR, 5'h00, d);
         chk("write data", d, wr_data);
         chk("controls", {12'h0, d[11:10], ae ? an_full_duplex : d[8],
            ae ? an_speed_100 : speed_sel},
            {12'h0, power_down_active, mii_isolate, full_duplex, speed_100});
         rd(5'h00, r);
         chk("read back", exp_rd(d, 1'h0), r);
      end
      an_enable <= 1'h0;
      wr(ADDR, 5'h00, 16'h0200);
      rd(5'h00, r);
      chk("restart off", {14'h0, an_restart_req, r[9]}, 16'h0000);
      an_enable <= 1'h1;
      wr(ADDR, 5'h00, 16'h0200);
      chk("restart req", {15'h0, an_restart_req}, 16'h0001);
      wr(ADDR, 5'h00, 16'h0000);
      rd(5'h00, r);
      chk("restart kept", {14'h0, an_restart_req, r[9]}, 16'h0003);
      an_started <= 1'h1;
      @(posedge clk);
      an_started <= 1'h0;
      repeat (4) @(posedge clk);
      rd(5'h00, r);
      chk("restart cleared", {14'h0, an_restart_req, r[9]}, 16'h0000);
      r = n_stb[15:0];
      wr(ADDR ^ 5'h01, 5'h00, 16'h0800);
      chk("other phy", {r[7:0], 7'h0, power_down_active}, {n_stb[7:0], 8'h00});
      i_phybc_smc_model.frame(2'h3, ADDR, 5'h00, 16'h0800, r);
      i_phybc_smc_model.frame(2'h2, ADDR ^ 5'h01, 5'h00, 16'h0000, r);
      chk("bad op, no drive", {r[15:1], power_down_active}, 16'hfffe);
      wr(ADDR, 5'h05, 16'h0800);
      rd(5'h05, r);
      chk("other reg", {r[7:0], 7'h0, power_down_active}, 16'h0000);
      power_down_irq_pin_n <= 1'h0;
      repeat (6) @(posedge clk);
      chk("pin down", {15'h0, power_down_active}, 16'h0001);
      power_down_irq_pin_n <= 1'h1;
      repeat (6) @(posedge clk);
      rd(5'h00, r);
      chk("pin latched", {14'h0, power_down_active, r[11]}, 16'h0003);
      for (int ct = 0; ct < 2; ct++)
      begin
         wr(ADDR, 5'h00, {8'h00, ct[0], 7'h7f});
         chk("pd cleared", {15'h0, power_down_active}, 16'h0000);
         tx_en <= 1'h1;
         repeat (4) @(posedge clk);
         chk("col on", {15'h0, col}, {15'h0, ct[0]});
         tx_en <= 1'h0;
         repeat (4) @(posedge clk);
         chk("col off", {15'h0, col}, 16'h0000);
      end
      test_done();
   end

   initial
   begin
      #600us;
      n_errors++;
      test_done();
   end
endmodule : tb_phy_basic_control_low_bits

bind phybc_top phybc_top_properties i_phybc_top_properties (.clk, .rstn, .ce, .tx_en,
   .power_down_irq_pin_n, .an_enable, .speed_sel, .an_started, .an_full_duplex,
   .an_speed_100, .col, .power_down_active, .mii_isolate, .an_restart_req, .full_duplex,
   .speed_100, .mdio_out, .mdio_oe, .wr_stb, .wr_data);

`default_nettype wire
